// [core/hdt_datalink_transmitter.sv]
`timescale 1ns/100ps
`include "hdt_consts.svh"
// Operation
// RULE1: enable set sends flags until data; enable clear sends all-ones idle.
// RULE2: check-sequence enable appends a CRC-16 (x16+x12+x5+1) to each frame.
// RULE3: check word goes out highest-order bit first.
// RULE4: abort finishes current byte, sends 01111111 zero first, flushes queue.
// RULE5: abort held sends aborts back to back and holds queue flushed.
// RULE6: each rising edge of abort sends at least one whole abort.
// RULE7: last-byte mark makes the byte followed by check word, then flags.
// RULE8: writing a data byte clears the last-byte mark.
// RULE9: writing one to the flush bit empties the queue.
// RULE10: shared-flag bit lets one flag close a frame and open the next.
// RULE11: sending starts above start threshold, stops at packet end below it.
// RULE12: software keeps start threshold above low-water unless both zero.
// RULE13: level empty or below low-water sets low-water flag and status.
// RULE14: each flag drives the interrupt output only when its enable is set.
// RULE15: reading interrupt status clears the four interrupt flags.
// RULE16: any write to interrupt status clears underrun.
// RULE17: queue empty inside a packet sets underrun flag.
// RULE18: data write into a full queue sets overrun flag.
// RULE19: full status while 128 bytes held; full flag set on becoming full.
// RULE20: below-low-water status tracks the live level.
// RULE21: data bytes are queued and sent least significant bit first.
// RULE22: software spaces register accesses at most one per eight clocks.
// RULE23: a zero is stuffed after five ones in data and check bits.
module hdt_datalink_transmitter #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // data link bit slots of the framer
    input wire logic dl_bit_req,
    output logic dl_bit,
    // interrupt
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////
    // registers and bus decode
    logic [7:0] config_ff;
    logic [6:0] start_thr_ff;
    logic [6:0] low_water_ff;
    logic [3:0] int_en_ff;
    logic [3:0] int_flag_ff;
    logic [7:0] last_byte_ff;
    logic abort_prev_ff;
    logic abort_pend_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic irq_n_ff;
    logic dl_bit_ff;

    logic [9:0] reg_idx;
    logic setup;
    logic access;
    logic wr_cfg;
    logic wr_status;
    logic wr_byte;
    logic rd_status;
    logic mapped;
    logic [7:0] rd_val;

    // byte address is four times the index; low two bits ignored
    assign reg_idx = paddr[11:2];
    assign setup = psel && !penable;
    assign access = psel && penable && pready_ff;
    assign mapped = reg_idx >= {2'b00, `HDT_IDX_TX_CONFIG}
        && reg_idx <= {2'b00, `HDT_IDX_TX_BYTE};
    assign wr_cfg = access && pwrite
        && reg_idx == {2'b00, `HDT_IDX_TX_CONFIG};
    assign wr_status = access && pwrite
        && reg_idx == {2'b00, `HDT_IDX_INT_STATUS};
    assign wr_byte = access && pwrite
        && reg_idx == {2'b00, `HDT_IDX_TX_BYTE};
    assign rd_status = access && !pwrite
        && reg_idx == {2'b00, `HDT_IDX_INT_STATUS};

    ////////////////////////////////////////////////////////////////////////
    // transmit queue
    logic [7:0] mem [DEPTH];
    logic [DEPTH-1:0] eom_mem_ff;
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic [AW:0] level;
    logic [AW:0] eom_cnt_ff;
    logic q_empty;
    logic q_full;
    logic below_low;
    logic flush;
    logic push;
    logic pop;
    logic mark_eom;
    logic pop_eom;

    assign level = wr_ptr_ff - rd_ptr_ff;
    assign q_empty = level == '0;
    assign q_full = level == (AW+1)'(DEPTH); // RULE19
    assign below_low = q_empty || level < {1'b0, low_water_ff}; // RULE20
    assign push = wr_byte && !q_full; // RULE21
    assign mark_eom = wr_cfg && pwdata[`HDT_CFG_EOM] && !q_empty;
    assign pop_eom = pop && eom_mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= pwdata[7:0]; // RULE21
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || flush) begin
            wr_ptr_ff <= '0; // RULE9
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    // end-of-packet tags ride beside the data, one per entry
    always_ff @(posedge core_clk) begin
        if (reset) begin
            eom_mem_ff <= '0;
        end else begin
            if (push) begin
                eom_mem_ff[wr_ptr_ff[AW-1:0]] <= 1'b0;
            end
            if (mark_eom) begin
                eom_mem_ff[wr_ptr_ff[AW-1:0] - 1'b1] <= 1'b1; // RULE7
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || flush) begin
            eom_cnt_ff <= '0;
        end else begin
            eom_cnt_ff <= eom_cnt_ff + (AW+1)'(mark_eom)
                - (AW+1)'(pop_eom);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            config_ff <= `HDT_RST_CONFIG;
        end else if (wr_cfg) begin
            config_ff <= pwdata[7:0];
            config_ff[`HDT_CFG_FLUSH] <= 1'b0;
            config_ff[5:4] <= 2'h0;
        end else if (wr_byte) begin
            config_ff[`HDT_CFG_EOM] <= 1'b0; // RULE8
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            start_thr_ff <= `HDT_RST_START_THR;
            low_water_ff <= `HDT_RST_LOW_WATER;
            int_en_ff <= `HDT_RST_INT_EN;
            last_byte_ff <= 8'h00;
        end else if (access && pwrite) begin
            if (reg_idx == {2'b00, `HDT_IDX_START_THR}) begin
                start_thr_ff <= pwdata[6:0];
            end
            if (reg_idx == {2'b00, `HDT_IDX_LOW_WATER}) begin
                low_water_ff <= pwdata[6:0];
            end
            if (reg_idx == {2'b00, `HDT_IDX_INT_EN}) begin
                int_en_ff <= pwdata[3:0];
            end
            if (wr_byte) begin
                last_byte_ff <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: data prepared in setup, pready in the access cycle
    always_comb begin
        rd_val = 8'h00;
        unique case (reg_idx)
            {2'b00, `HDT_IDX_TX_CONFIG}: rd_val = config_ff;
            {2'b00, `HDT_IDX_START_THR}: rd_val = {1'b0, start_thr_ff};
            {2'b00, `HDT_IDX_LOW_WATER}: rd_val = {1'b0, low_water_ff};
            {2'b00, `HDT_IDX_INT_EN}: rd_val = {4'h0, int_en_ff};
            {2'b00, `HDT_IDX_INT_STATUS}: begin
                rd_val = {1'b0, q_full, below_low, 1'b0, int_flag_ff};
            end
            {2'b00, `HDT_IDX_TX_BYTE}: rd_val = last_byte_ff;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            if (setup) begin
                prdata_ff <= {24'h0, rd_val};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags; a set in the same cycle as a clear wins
    logic below_prev_ff;
    logic full_prev_ff;
    logic [3:0] flag_set;
    logic udr_event;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            below_prev_ff <= 1'b1;
            full_prev_ff <= 1'b0;
        end else begin
            below_prev_ff <= below_low;
            full_prev_ff <= q_full;
        end
    end

    always_comb begin
        flag_set = 4'h0;
        flag_set[`HDT_INT_LOW] = below_low && !below_prev_ff; // RULE13
        flag_set[`HDT_INT_UDR] = udr_event; // RULE17
        flag_set[`HDT_INT_OVR] = wr_byte && q_full; // RULE18
        flag_set[`HDT_INT_FULL] = q_full && !full_prev_ff; // RULE19
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            int_flag_ff <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (flag_set[i]) begin
                    int_flag_ff[i] <= 1'b1;
                end else if (rd_status) begin
                    int_flag_ff[i] <= 1'b0; // RULE15
                end else if (wr_status && i == `HDT_INT_UDR) begin
                    int_flag_ff[i] <= 1'b0; // RULE16
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= !(|(int_flag_ff & int_en_ff)); // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serializer
    hdt_pkg::hdt_mode_t mode_ff;
    hdt_pkg::hdt_mode_t nxt_mode;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic [4:0] bits_left_ff;
    logic [4:0] nxt_bits;
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    logic [2:0] ones_ff;
    logic frame_open_ff;
    logic nxt_open;
    logic closing_ff;
    logic nxt_closing;
    logic eom_last_ff;
    logic draining_ff;
    logic stuff;
    logic byte_end;
    logic go;
    logic [7:0] head;
    logic abort_now;

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ `HDT_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_byte

    assign head = mem[rd_ptr_ff[AW-1:0]];
    // ones are only counted in data and check bits, so a run that ends a
    // frame is still broken up before the closing flag or abort goes out
    assign stuff = ones_ff == `HDT_STUFF_RUN; // RULE23
    assign byte_end = dl_bit_req && !stuff && bits_left_ff == 5'd1;
    assign abort_now = abort_pend_ff || config_ff[`HDT_CFG_ABT];
    assign go = draining_ff && !q_empty;

    // next unit to send, chosen when the last bit of the current one leaves
    always_comb begin
        nxt_mode = hdt_pkg::HDT_FLAG;
        nxt_shift = {8'h00, `HDT_FLAG_BYTE};
        nxt_bits = 5'd8;
        nxt_crc = crc_ff;
        nxt_open = 1'b0;
        nxt_closing = 1'b0;
        pop = 1'b0;
        flush = wr_cfg && pwdata[`HDT_CFG_FLUSH]; // RULE9
        udr_event = 1'b0;
        if (byte_end) begin
            if (abort_now) begin
                nxt_mode = hdt_pkg::HDT_ABORT; // RULE4 RULE5 RULE6
                nxt_shift = {8'h00, `HDT_ABORT_BYTE};
                flush = 1'b1; // RULE4
            end else if (!config_ff[`HDT_CFG_EN]) begin
                nxt_mode = hdt_pkg::HDT_IDLE; // RULE1
                nxt_shift = {8'h00, `HDT_IDLE_BYTE};
            end else if (mode_ff == hdt_pkg::HDT_DATA && eom_last_ff) begin
                if (config_ff[`HDT_CFG_CRC]) begin
                    nxt_mode = hdt_pkg::HDT_CRC; // RULE2 RULE7
                    nxt_shift = ~crc_ff;
                    nxt_bits = 5'd16;
                    nxt_open = 1'b1;
                end else begin
                    nxt_closing = 1'b1; // RULE7
                end
            end else if (mode_ff == hdt_pkg::HDT_CRC) begin
                nxt_closing = 1'b1;
            end else if (frame_open_ff) begin
                if (!q_empty) begin
                    nxt_mode = hdt_pkg::HDT_DATA;
                    nxt_shift = {8'h00, head};
                    nxt_crc = crc_byte(crc_ff, head);
                    nxt_open = 1'b1;
                    pop = 1'b1;
                end else begin
                    nxt_mode = hdt_pkg::HDT_ABORT; // RULE17
                    nxt_shift = {8'h00, `HDT_ABORT_BYTE};
                    udr_event = 1'b1;
                end
            end else if (go && mode_ff == hdt_pkg::HDT_FLAG
                         && (config_ff[`HDT_CFG_SHARE] || !closing_ff)) begin
                nxt_mode = hdt_pkg::HDT_DATA; // RULE10 RULE11
                nxt_shift = {8'h00, head};
                nxt_crc = crc_byte(`HDT_CRC_INIT, head); // RULE2
                nxt_open = 1'b1;
                pop = 1'b1;
            end
        end
        // abort keeps the queue flushed for as long as it is held
        if (config_ff[`HDT_CFG_ABT]) begin
            flush = 1'b1; // RULE5
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_ff <= hdt_pkg::HDT_IDLE;
            shift_ff <= {8'h00, `HDT_IDLE_BYTE};
            bits_left_ff <= 5'd8;
            crc_ff <= `HDT_CRC_INIT;
            frame_open_ff <= 1'b0;
            closing_ff <= 1'b0;
            eom_last_ff <= 1'b0;
        end else if (byte_end) begin
            mode_ff <= nxt_mode;
            shift_ff <= nxt_shift;
            bits_left_ff <= nxt_bits;
            crc_ff <= nxt_crc;
            frame_open_ff <= nxt_open;
            closing_ff <= nxt_closing;
            eom_last_ff <= pop_eom;
        end else if (dl_bit_req && !stuff) begin
            bits_left_ff <= bits_left_ff - 5'd1;
            if (mode_ff == hdt_pkg::HDT_CRC) begin
                shift_ff <= {shift_ff[14:0], 1'b0}; // RULE3
            end else begin
                shift_ff <= {1'b0, shift_ff[15:1]}; // RULE21
            end
        end
    end

    // the outgoing bit is chosen from the unit still being shifted
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dl_bit_ff <= 1'b1;
            ones_ff <= 3'h0;
        end else if (dl_bit_req) begin
            if (stuff) begin
                dl_bit_ff <= 1'b0; // RULE23
                ones_ff <= 3'h0;
            end else if (mode_ff == hdt_pkg::HDT_CRC) begin
                dl_bit_ff <= shift_ff[15]; // RULE3
                ones_ff <= shift_ff[15] ? ones_ff + 3'h1 : 3'h0;
            end else if (mode_ff == hdt_pkg::HDT_DATA) begin
                dl_bit_ff <= shift_ff[0]; // RULE21
                ones_ff <= shift_ff[0] ? ones_ff + 3'h1 : 3'h0;
            end else begin
                dl_bit_ff <= shift_ff[0];
                ones_ff <= 3'h0;
            end
        end
    end

    // abort edge is remembered until an abort byte is actually loaded
    always_ff @(posedge core_clk) begin
        if (reset) begin
            abort_prev_ff <= 1'b0;
            abort_pend_ff <= 1'b0;
        end else begin
            abort_prev_ff <= config_ff[`HDT_CFG_ABT];
            if (config_ff[`HDT_CFG_ABT] && !abort_prev_ff) begin
                abort_pend_ff <= 1'b1; // RULE6
            end else if (byte_end) begin
                abort_pend_ff <= 1'b0;
            end
        end
    end

    // once started, drain until no packet is open or queued and level is at or below threshold
    always_ff @(posedge core_clk) begin
        if (reset) begin
            draining_ff <= 1'b0;
        end else if (level > {1'b0, start_thr_ff} || eom_cnt_ff != '0) begin
            draining_ff <= 1'b1; // RULE11
        end else if (!frame_open_ff) begin
            draining_ff <= 1'b0; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign dl_bit = dl_bit_ff;
    assign irq_n = irq_n_ff;

endmodule : hdt_datalink_transmitter

// [include/hdt_consts.svh]
`ifndef HDT_CONSTS_SVH
`define HDT_CONSTS_SVH
// register indices; byte address is four times the index
`define HDT_IDX_TX_CONFIG 8'h34
`define HDT_IDX_START_THR 8'h35
`define HDT_IDX_LOW_WATER 8'h36
`define HDT_IDX_INT_EN 8'h37
`define HDT_IDX_INT_STATUS 8'h38
`define HDT_IDX_TX_BYTE 8'h39
// config fields
`define HDT_CFG_EN 0
`define HDT_CFG_CRC 1
`define HDT_CFG_ABT 2
`define HDT_CFG_EOM 3
`define HDT_CFG_FLUSH 6
`define HDT_CFG_SHARE 7
// interrupt flag / enable positions, then status bit positions
`define HDT_INT_LOW 0
`define HDT_INT_UDR 1
`define HDT_INT_OVR 2
`define HDT_INT_FULL 3
`define HDT_ST_BELOW 5
`define HDT_ST_FULL 6
// reset values
`define HDT_RST_CONFIG 8'h82
`define HDT_RST_START_THR 7'h40
`define HDT_RST_LOW_WATER 7'h07
`define HDT_RST_INT_EN 4'h0
// line codes, sent lsb first, then check word constants, sent msb first
`define HDT_FLAG_BYTE 8'h7e
`define HDT_ABORT_BYTE 8'hfe
`define HDT_IDLE_BYTE 8'hff
`define HDT_CRC_INIT 16'hffff
`define HDT_CRC_POLY 16'h1021
`define HDT_STUFF_RUN 3'h5
`endif

// [include/hdt_pkg.sv]
package hdt_pkg;
    typedef enum logic [4:0] {
        HDT_IDLE = 5'b00001,
        HDT_FLAG = 5'b00010,
        HDT_DATA = 5'b00100,
        HDT_CRC = 5'b01000,
        HDT_ABORT = 5'b10000
    } hdt_mode_t;
endpackage : hdt_pkg

// [tb/hdt_dl_partner.sv]
`timescale 1ns/100ps
module hdt_dl_partner (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // idle cycles between two bit slots
    input wire logic [3:0] gap,
    // data link bit slots
    input wire logic dl_bit,
    output logic dl_bit_req,
    // captured bits towards the bench
    output logic rx_bit,
    output logic rx_valid
);
logic [3:0] cnt_ff;
logic req_d_ff;
// slots come at a fixed pace, never waiting for the transmitter
always_ff @(posedge core_clk) begin
    if (reset || cnt_ff >= gap) begin
        cnt_ff <= 4'h0;
    end else begin
        cnt_ff <= cnt_ff + 4'h1;
    end
end
always_ff @(posedge core_clk) begin
    dl_bit_req <= !reset && cnt_ff >= gap;
    req_d_ff <= !reset && dl_bit_req;
end
// the bit answers the slot one edge later, so take it then
always_ff @(posedge core_clk) begin
    rx_valid <= req_d_ff;
    rx_bit <= dl_bit;
end
endmodule : hdt_dl_partner

// [tb/hdt_checker.sv]
`timescale 1ns/100ps
module hdt_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // data link
    input wire logic dl_bit_req,
    input wire logic dl_bit,
    // interrupt
    input wire logic irq_n
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (reset);
logic [3:0] int_en_ff;
logic quiet_ff;
logic acc;
logic mapped;
assign acc = psel && penable && pready && pwrite;
assign mapped = paddr[11:2] >= 10'h034 && paddr[11:2] <= 10'h039;
always_ff @(posedge core_clk) begin
    if (reset) begin
        int_en_ff <= 4'h0;
    end else if (acc && paddr[11:2] == 10'h037) begin
        int_en_ff <= pwdata[3:0];
    end
end
// line must stay at ones until the first enable lands
always_ff @(posedge core_clk) begin
    if (reset) begin
        quiet_ff <= 1'b1;
    end else if (acc && paddr[11:2] == 10'h034 && pwdata[0]) begin
        quiet_ff <= 1'b0;
    end
end
//////////////////////////////////////////////////
sequence s_setup;
    psel && !penable;
endsequence
sequence s_access;
    psel && penable && pready;
endsequence
a_answer_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
a_err_unmapped: assert property (s_access |-> pslverr == !mapped)
    else $error("error flag wrong");
a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
a_read_upper: assert property ((s_access ##0 !pwrite) |->
    prdata[31:8] == 24'h0 && (mapped || prdata == 32'h0))
    else $error("read data bits wrong");
a_bit_holds: assert property (!dl_bit_req |=> $stable(dl_bit))
    else $error("bit moved without slot");
a_quiet_ones: assert property (quiet_ff |-> dl_bit)
    else $error("line not idle ones");
a_mask_irq: assert property (int_en_ff == 4'h0 &&
    $past(int_en_ff) == 4'h0 |-> irq_n)
    else $error("masked interrupt seen");
endmodule : hdt_checker
bind hdt_datalink_transmitter hdt_checker u_chk (
    .core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dl_bit_req(dl_bit_req), .dl_bit(dl_bit), .irq_n(irq_n)
);

// [tb/tb_hdt_datalink_transmitter.sv]
`timescale 1ns/100ps
module tb_hdt_datalink_transmitter;
logic core_clk = 1'b0;
logic reset = 1'b1;
logic [11:0] paddr = 12'h000;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic dl_bit_req;
logic dl_bit;
logic irq_n;
logic [3:0] gap = 4'h0;
logic rx_bit;
logic rx_valid;
logic rxq[$];
int n_errors = 0;
int samples_checked = 0;
int cyc = 0;
always #2.5 core_clk = ~core_clk;
hdt_datalink_transmitter dut_u (
    .core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dl_bit_req(dl_bit_req), .dl_bit(dl_bit), .irq_n(irq_n)
);
hdt_dl_partner peer_u (
    .core_clk(core_clk), .reset(reset), .gap(gap), .dl_bit(dl_bit),
    .dl_bit_req(dl_bit_req), .rx_bit(rx_bit), .rx_valid(rx_valid)
);
always @(posedge core_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_bit);
    cyc++;
    if (cyc == 20000) begin
        n_errors++;
        $display("Error at %0t: timeout", $time);
        print_verdict();
    end
end
//////////////////////////////////////////////////
task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask : print_verdict
task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
        n_errors++;
        $display("Error at %0t: %s", $time, msg);
    end
endtask : chk
task automatic apb(input logic wr, input logic [7:0] idx,
                   input logic [7:0] wd, output logic [31:0] rd,
                   output logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && t < 40) begin
        t++;
        @(posedge core_clk);
    end
    chk(t < 40, "no ready");
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (8) @(posedge core_clk);
endtask : apb
task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, idx, d, rd, e);
endtask : wr
task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
                   input logic [7:0] x, input string msg);
    logic [31:0] rd;
    logic e;
    apb(1'b0, idx, 8'h00, rd, e);
    chk((rd[7:0] & m) === x && e === 1'b0, msg);
endtask : rdc
task automatic wait_bits(input int n);
    int t;
    t = 0;
    while (rxq.size() < n && t < 3000) begin
        t++;
        @(posedge core_clk);
    end
    chk(t < 3000, "bit wait");
endtask : wait_bits
function automatic int n_aborts();
    logic [7:0] w;
    int n;
    // start from ones so a leading run is not taken for an abort
    w = 8'hff;
    n = 0;
    foreach (rxq[k]) begin
        w = {rxq[k], w[7:1]};
        if (w == 8'hfe) n++;
    end
    return n;
endfunction : n_aborts
// bits between the first two flags that are not back to back, stuffed zeros removed
task automatic get_bits(output logic got[$]);
    logic [7:0] w;
    int last;
    int ones;
    w = 8'h00;
    last = -1;
    ones = 0;
    got.delete();
    for (int i = 0; i < rxq.size(); i++) begin
        w = {rxq[i], w[7:1]};
        if (w == 8'h7e) begin
            if (last >= 0 && i - 8 > last) begin
                for (int j = last + 1; j <= i - 8; j++) begin
                    if (ones == 5 && rxq[j] == 1'b0) begin
                        ones = 0;
                    end else begin
                        got.push_back(rxq[j]);
                        ones = rxq[j] ? ones + 1 : 0;
                    end
                end
                return;
            end
            last = i;
        end
    end
endtask : get_bits
//////////////////////////////////////////////////
task automatic t_reset;
    logic [31:0] rd;
    logic e;
    logic ok;
    rdc(8'h34, 8'hff, 8'h82, "config reset");
    rdc(8'h35, 8'h7f, 8'h40, "start reset");
    rdc(8'h36, 8'h7f, 8'h07, "low reset");
    rdc(8'h37, 8'h0f, 8'h00, "enable reset");
    rdc(8'h38, 8'h60, 8'h20, "status reset");
    apb(1'b0, 8'h3a, 8'h00, rd, e);
    chk(e === 1'b1 && rd === 32'h0, "unmapped read");
    wait_bits(24);
    ok = 1'b1;
    foreach (rxq[k]) if (rxq[k] !== 1'b1) ok = 1'b0;
    chk(ok, "idle not ones");
    $display("reset test done");
endtask : t_reset
task automatic t_frame(input logic crc);
    logic [7:0] d[3];
    logic got[$];
    logic exp[$];
    logic [15:0] c;
    logic ok;
    d = '{8'hff, 8'h3e, 8'h81};
    c = 16'hffff;
    wr(8'h34, {6'b110000, crc, 1'b1});
    rxq.delete();
    foreach (d[k]) wr(8'h39, d[k]);
    wr(8'h34, {5'b10001, 1'b0, crc, 1'b1});
    wait_bits(200);
    get_bits(got);
    foreach (d[k]) begin
        for (int b = 0; b < 8; b++) begin
            exp.push_back(d[k][b]);
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k][b]) ? 16'h1021 : 16'h0);
        end
    end
    if (crc) for (int b = 15; b >= 0; b--) exp.push_back(~c[b]);
    ok = got.size() == exp.size();
    foreach (exp[k]) if (k < got.size() && got[k] !== exp[k]) ok = 1'b0;
    chk(ok, "frame bits");
    wr(8'h39, 8'h55);
    rdc(8'h34, 8'h08, 8'h00, "last-byte mark kept");
    $display("frame test done");
endtask : t_frame
task automatic t_abort;
    wr(8'h34, 8'hc3);
    wr(8'h35, 8'h40);
    wr(8'h36, 8'h00);
    wr(8'h39, 8'h11);
    wr(8'h39, 8'h22);
    rdc(8'h38, 8'h20, 8'h00, "queue empty early");
    wr(8'h34, 8'h87);
    rxq.delete();
    wait_bits(48);
    chk(n_aborts() >= 2, "aborts not repeated");
    rdc(8'h38, 8'h20, 8'h20, "queue kept");
    wr(8'h34, 8'h83);
    rxq.delete();
    wait_bits(32);
    // slow slots so the bit is cleared before one abort could finish
    gap <= 4'h3;
    rxq.delete();
    wr(8'h34, 8'h87);
    wr(8'h34, 8'h83);
    wait_bits(40);
    chk(n_aborts() >= 1, "short abort lost");
    $display("abort test done");
endtask : t_abort
task automatic t_underrun;
    int t;
    t = 0;
    gap <= 4'h0;
    wr(8'h34, 8'hc3);
    wr(8'h35, 8'h01);
    wr(8'h37, 8'h02);
    wr(8'h39, 8'h5a);
    rxq.delete();
    wait_bits(24);
    chk(irq_n === 1'b1, "sent at threshold");
    wr(8'h39, 8'ha5);
    while (irq_n !== 1'b0 && t < 200) begin
        t++;
        @(posedge core_clk);
    end
    chk(irq_n === 1'b0, "no underrun irq");
    wr(8'h38, 8'h00);
    chk(irq_n === 1'b1, "underrun kept");
    $display("underrun test done");
endtask : t_underrun
task automatic t_full;
    wr(8'h34, 8'hc2);
    wr(8'h37, 8'h0c);
    rdc(8'h38, 8'h40, 8'h00, "full early");
    for (int k = 0; k < 128; k++) wr(8'h39, k[7:0]);
    chk(irq_n === 1'b0, "no full irq");
    wr(8'h39, 8'hee);
    rdc(8'h38, 8'h6c, 8'h4c, "full and overrun");
    rdc(8'h38, 8'h0f, 8'h00, "flags kept");
    chk(irq_n === 1'b1, "irq stuck");
    wr(8'h34, 8'hc2);
    rdc(8'h38, 8'h61, 8'h21, "flush");
    chk(irq_n === 1'b1, "masked low irq");
    $display("full test done");
endtask : t_full
initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_frame(1'b1);
    t_frame(1'b0);
    t_abort();
    t_underrun();
    t_full();
    print_verdict();
end
endmodule : tb_hdt_datalink_transmitter
